// ### rtl/ecb_top.sv
// Control register two, buffer pointers, packet count and the shared packet buffer.
`timescale 1ns/1ps
`include "ecb_cfg.svh"
module ecb_top
   import ecb_pkg::*;
#(
   parameter int ADDR_W = `ECB_ADDR_W,
   parameter int DEPTH = `ECB_MEM_DEPTH
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [4:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   input wire logic i_buf_rd,
   input wire logic i_buf_wr,
   input wire logic [7:0] i_buf_wdata,
   output logic [7:0] o_buf_rdata,
   output logic o_buf_rvalid,
   input wire logic i_pkt_received,
   output logic o_sleep,
   output logic o_regulator_low_current
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   ecb_ctl_t ctl;
   ecb_ctl_t next_ctl;
   ecb_ptrs_t ptrs;
   ecb_ptrs_t next_ptrs;
   logic [7:0] pending_packet_count;
   logic [7:0] next_pending_packet_count;
   logic [7:0] next_reg_rdata;
   logic next_sleep;
   logic next_low_current;
   logic [7:0] ctl_byte;
   logic [7:0] mem_rdata;

   assign ctl_byte = {ctl.auto_pointer_advance, ctl.packet_count_decrement,
                      ctl.low_power_sleep_enable, 1'b0, ctl.regulator_low_current_select,
                      3'h0};

   // ----------------------------------------
   // Control register two
   // ----------------------------------------
   always_comb begin
      next_ctl = ctl;
      next_ctl.packet_count_decrement = 1'b0;
      if (i_reg_wr && i_reg_addr == `ECB_REG_CTL2) begin
         next_ctl.auto_pointer_advance = i_reg_wdata[`ECB_BIT_AUTO];
         next_ctl.packet_count_decrement = i_reg_wdata[`ECB_BIT_DEC];
         next_ctl.low_power_sleep_enable = i_reg_wdata[`ECB_BIT_SLEEP];
         next_ctl.regulator_low_current_select = i_reg_wdata[`ECB_BIT_REGULATOR_LOW_CURRENT_SELECT];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ctl <= ecb_ctl_t'({1'b1, 1'b0, 1'b0, 1'b0});
      end else begin
         ctl <= next_ctl;
      end
   end

   // ----------------------------------------
   // Pointers
   // ----------------------------------------
   always_comb begin
      next_ptrs = ptrs;
      if (i_buf_rd && ctl.auto_pointer_advance) begin
         if (ptrs.buffer_read_pointer == ptrs.rx_end) begin
            next_ptrs.buffer_read_pointer = ptrs.rx_start;
         end else begin
            next_ptrs.buffer_read_pointer = ptrs.buffer_read_pointer + 13'h0001;
         end
      end
      if (i_buf_wr && ctl.auto_pointer_advance) begin
         next_ptrs.buffer_write_pointer = ptrs.buffer_write_pointer + 13'h0001;
      end
      if (i_reg_wr) begin
         case (i_reg_addr)
            `ECB_REG_RDPT_LO: next_ptrs.buffer_read_pointer[7:0] = i_reg_wdata;
            `ECB_REG_RDPT_HI: next_ptrs.buffer_read_pointer[12:8] = i_reg_wdata[4:0];
            `ECB_REG_WRPT_LO: next_ptrs.buffer_write_pointer[7:0] = i_reg_wdata;
            `ECB_REG_WRPT_HI: next_ptrs.buffer_write_pointer[12:8] = i_reg_wdata[4:0];
            `ECB_REG_RXST_LO: next_ptrs.rx_start[7:0] = i_reg_wdata;
            `ECB_REG_RXST_HI: next_ptrs.rx_start[12:8] = i_reg_wdata[4:0];
            `ECB_REG_RXND_LO: next_ptrs.rx_end[7:0] = i_reg_wdata;
            `ECB_REG_RXND_HI: next_ptrs.rx_end[12:8] = i_reg_wdata[4:0];
            default: next_ptrs = next_ptrs;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ptrs <= ecb_ptrs_t'({`ECB_RST_PTR, `ECB_RST_PTR, `ECB_RST_PTR, `ECB_RST_RXND});
      end else begin
         ptrs <= next_ptrs;
      end
   end

   // ----------------------------------------
   // Pending packet count
   // ----------------------------------------
   always_comb begin
      next_pending_packet_count = pending_packet_count;
      if (i_pkt_received && !ctl.packet_count_decrement &&
          pending_packet_count != `ECB_PKTCNT_MAX) begin
         next_pending_packet_count = pending_packet_count + 8'h01;
      end else if (ctl.packet_count_decrement && !i_pkt_received &&
                   pending_packet_count != `ECB_RST_PKTCNT) begin
         next_pending_packet_count = pending_packet_count - 8'h01;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         pending_packet_count <= `ECB_RST_PKTCNT;
      end else begin
         pending_packet_count <= next_pending_packet_count;
      end
   end

   // ----------------------------------------
   // Read-back and power outputs
   // ----------------------------------------
   always_comb begin
      next_reg_rdata = o_reg_rdata;
      if (i_reg_rd) begin
         case (i_reg_addr)
            `ECB_REG_RDPT_LO: next_reg_rdata = ptrs.buffer_read_pointer[7:0];
            `ECB_REG_RDPT_HI: next_reg_rdata = {3'h0, ptrs.buffer_read_pointer[12:8]};
            `ECB_REG_WRPT_LO: next_reg_rdata = ptrs.buffer_write_pointer[7:0];
            `ECB_REG_WRPT_HI: next_reg_rdata = {3'h0, ptrs.buffer_write_pointer[12:8]};
            `ECB_REG_RXST_LO: next_reg_rdata = ptrs.rx_start[7:0];
            `ECB_REG_RXST_HI: next_reg_rdata = {3'h0, ptrs.rx_start[12:8]};
            `ECB_REG_RXND_LO: next_reg_rdata = ptrs.rx_end[7:0];
            `ECB_REG_RXND_HI: next_reg_rdata = {3'h0, ptrs.rx_end[12:8]};
            `ECB_REG_PKTCNT: next_reg_rdata = pending_packet_count;
            `ECB_REG_CTL2: next_reg_rdata = ctl_byte;
            default: next_reg_rdata = 8'h00;
         endcase
      end
      next_sleep = next_ctl.low_power_sleep_enable;
      next_low_current = next_ctl.low_power_sleep_enable &&
                         next_ctl.regulator_low_current_select;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_reg_rdata <= 8'h00;
         o_sleep <= 1'b0;
         o_regulator_low_current <= 1'b0;
         o_buf_rvalid <= 1'b0;
      end else begin
         o_reg_rdata <= next_reg_rdata;
         o_sleep <= next_sleep;
         o_regulator_low_current <= next_low_current;
         o_buf_rvalid <= i_buf_rd;
      end
   end

   // ----------------------------------------
   // Shared packet memory
   // ----------------------------------------
   ecb_mem #(
      .ADDR_W(ADDR_W),
      .DEPTH(DEPTH)
   ) u_mem (
      .i_ref_clk(i_ref_clk),
      .i_wr(i_buf_wr),
      .i_wr_addr(ptrs.buffer_write_pointer),
      .i_wr_data(i_buf_wdata),
      .i_rd(i_buf_rd),
      .i_rd_addr(ptrs.buffer_read_pointer),
      .o_rd_data(mem_rdata)
   );
   assign o_buf_rdata = mem_rdata;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence rd_adv_s;
      i_buf_rd && ctl.auto_pointer_advance && !i_reg_wr &&
      ptrs.buffer_read_pointer != ptrs.rx_end;
   endsequence

   sequence dec_wr_s;
      i_reg_wr && i_reg_addr == `ECB_REG_CTL2 && i_reg_wdata[`ECB_BIT_DEC];
   endsequence

   read_advance_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      rd_adv_s |=> ptrs.buffer_read_pointer == $past(ptrs.buffer_read_pointer) + 13'h0001)
      else $error("Read pointer did not advance.");

   write_advance_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_buf_wr && ctl.auto_pointer_advance && !i_reg_wr
      |=> ptrs.buffer_write_pointer == $past(ptrs.buffer_write_pointer) + 13'h0001)
      else $error("Write pointer did not advance.");

   ptr_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !ctl.auto_pointer_advance && !i_reg_wr |=> $stable(ptrs))
      else $error("Pointers moved with auto advance clear.");

   count_dec_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      dec_wr_s ##1 (!i_pkt_received && pending_packet_count != 8'h00)
      |=> pending_packet_count == $past(pending_packet_count) - 8'h01)
      else $error("Packet count not decremented by one.");

   dec_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      dec_wr_s ##1 !i_reg_wr |=> !ctl.packet_count_decrement)
      else $error("Decrement bit did not clear itself.");

   sleep_out_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_sleep == ctl.low_power_sleep_enable)
      else $error("Sleep output does not follow control bit.");

   low_current_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_regulator_low_current |-> o_sleep)
      else $error("Low current selected outside sleep.");

   sleep_write_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_reg_wr && i_reg_addr == `ECB_REG_CTL2
      |=> o_sleep == $past(i_reg_wdata[`ECB_BIT_SLEEP]))
      else $error("Sleep output does not follow written bit.");

   current_write_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_reg_wr && i_reg_addr == `ECB_REG_CTL2
      |=> o_regulator_low_current ==
      ($past(i_reg_wdata[`ECB_BIT_SLEEP]) && $past(i_reg_wdata[`ECB_BIT_REGULATOR_LOW_CURRENT_SELECT])))
      else $error("Low current output does not follow written bits.");

   read_wrap_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_buf_rd && ctl.auto_pointer_advance && !i_reg_wr &&
      ptrs.buffer_read_pointer == ptrs.rx_end
      |=> ptrs.buffer_read_pointer == $past(ptrs.rx_start))
      else $error("Read pointer did not wrap to receive start.");

   low_bits_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_reg_rd && i_reg_addr == `ECB_REG_CTL2
      |=> o_reg_rdata[4] == 1'b0 && o_reg_rdata[2:0] == 3'h0)
      else $error("Unimplemented bits read nonzero.");

   rvalid_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_buf_rd |=> o_buf_rvalid)
      else $error("Buffer read data not marked valid.");
endmodule : ecb_top

// ### rtl/ecb_cfg.svh
// Register offsets, field positions and reset values of the control and buffer block.
`ifndef ECB_CFG_SVH
`define ECB_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ECB_REG_RDPT_LO 5'h00
`define ECB_REG_RDPT_HI 5'h01
`define ECB_REG_WRPT_LO 5'h02
`define ECB_REG_WRPT_HI 5'h03
`define ECB_REG_RXST_LO 5'h08
`define ECB_REG_RXST_HI 5'h09
`define ECB_REG_RXND_LO 5'h0A
`define ECB_REG_RXND_HI 5'h0B
`define ECB_REG_PKTCNT 5'h19
`define ECB_REG_CTL2 5'h1E
// ----------------------------------------
// Control two field positions
// ----------------------------------------
`define ECB_BIT_AUTO 7
`define ECB_BIT_DEC 6
`define ECB_BIT_SLEEP 5
`define ECB_BIT_REGULATOR_LOW_CURRENT_SELECT 3
// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define ECB_ADDR_W 13
`define ECB_MEM_DEPTH 8192
`define ECB_RST_CTL2 8'h80
`define ECB_RST_PTR 13'h0000
`define ECB_RST_RXND 13'h1FFF
`define ECB_RST_PKTCNT 8'h00
`define ECB_PKTCNT_MAX 8'hFF
`endif

// ### rtl/ecb_pkg.sv
// Types shared by the control and buffer block.
package ecb_pkg;
   typedef struct packed {
      logic auto_pointer_advance;
      logic packet_count_decrement;
      logic low_power_sleep_enable;
      logic regulator_low_current_select;
   } ecb_ctl_t;

   typedef struct packed {
      logic [12:0] buffer_read_pointer;
      logic [12:0] buffer_write_pointer;
      logic [12:0] rx_start;
      logic [12:0] rx_end;
   } ecb_ptrs_t;
endpackage : ecb_pkg

// ### rtl/ecb_mem.sv
// Shared packet memory with one write port and one registered read port.
`timescale 1ns/1ps
module ecb_mem
   import ecb_pkg::*;
#(
   parameter int ADDR_W = 13,
   parameter int DEPTH = 8192
) (
   input wire logic i_ref_clk,
   input wire logic i_wr,
   input wire logic [ADDR_W-1:0] i_wr_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_rd,
   input wire logic [ADDR_W-1:0] i_rd_addr,
   output logic [7:0] o_rd_data
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge i_ref_clk) begin
      if (i_wr) begin
         mem[i_wr_addr] <= i_wr_data;
      end
      if (i_rd) begin
         o_rd_data <= mem[i_rd_addr];
      end
   end
endmodule : ecb_mem

// ### testbench/ecb_host_model.sv
// Host controller model driving the register bus and the buffer data port.
`timescale 1ns/1ps
module ecb_host_model (
   input wire logic i_ref_clk,
   output logic o_reg_wr,
   output logic o_reg_rd,
   output logic [4:0] o_reg_addr,
   output logic [7:0] o_reg_wdata,
   output logic o_buf_rd,
   output logic o_buf_wr,
   output logic [7:0] o_buf_wdata
);
   // ----------------------------------------
   // Request driver
   // ----------------------------------------
   initial begin
      {o_reg_wr, o_reg_rd, o_buf_wr, o_buf_rd} = 4'h0;
      o_reg_addr = 5'h00;
      o_reg_wdata = 8'h00;
      o_buf_wdata = 8'h00;
   end

   // Kind bits are register write, register read, buffer write, buffer read.
   // Released buses show the inverse of the last value, never a stale copy.
   task automatic op(input logic [3:0] k, input logic [4:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      #1;
      {o_reg_wr, o_reg_rd, o_buf_wr, o_buf_rd} = k;
      o_reg_addr = a;
      o_reg_wdata = d;
      o_buf_wdata = d;
      @(posedge i_ref_clk);
      #1;
      {o_reg_wr, o_reg_rd, o_buf_wr, o_buf_rd} = 4'h0;
      o_reg_addr = ~a;
      o_reg_wdata = ~d;
      o_buf_wdata = ~d;
   endtask : op
endmodule : ecb_host_model

// ### testbench/ethernet_control_two_and_buffer_tb.sv
// Self-checking testbench of the control register two and packet buffer block.
`timescale 1ns/1ps
`include "ecb_cfg.svh"
module ethernet_control_two_and_buffer_tb
   import ecb_pkg::*;
;
   logic i_ref_clk;
   logic i_sys_rst;
   logic i_pkt_received;
   logic reg_wr, reg_rd, buf_rd, buf_wr, buf_rvalid, sleep_lvl, reg_low;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, buf_wdata, reg_rdata, buf_rdata, d;
   logic [7:0] bytes [0:3];
   logic [12:0] s, p, q;
   int err_count = 0;
   int cmp_count = 0;
   int seed = 85443;
   int cycles = 0;
   int n;

   ecb_top i_ecb_top (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(reg_wr),
      .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .o_reg_rdata(reg_rdata), .i_buf_rd(buf_rd), .i_buf_wr(buf_wr),
      .i_buf_wdata(buf_wdata), .o_buf_rdata(buf_rdata), .o_buf_rvalid(buf_rvalid),
      .i_pkt_received(i_pkt_received), .o_sleep(sleep_lvl),
      .o_regulator_low_current(reg_low));
   ecb_host_model i_ecb_host_model (.i_ref_clk(i_ref_clk), .o_reg_wr(reg_wr),
      .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
      .o_buf_rd(buf_rd), .o_buf_wr(buf_wr), .o_buf_wdata(buf_wdata));

   // ----------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count = err_count + 1;
         conclude();
      end
   end

   task automatic conclude();
      $display("counts: %0d compared, %0d mismatched", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      i_ecb_host_model.op(4'h8, a, v);
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [7:0] v);
      i_ecb_host_model.op(4'h4, a, 8'h00);
      v = reg_rdata;
   endtask : rd

   task automatic set_ptr(input logic [4:0] lo, input logic [12:0] v);
      wr(lo, v[7:0]);
      wr(lo + 5'h01, {3'b000, v[12:8]});
   endtask : set_ptr

   task automatic get_ptr(input logic [4:0] lo, output logic [12:0] v);
      logic [7:0] l;
      logic [7:0] h;
      rd(lo, l);
      rd(lo + 5'h01, h);
      v = {h[4:0], l};
   endtask : get_ptr

   // Next read address: back to the receive start after the receive end.
   function automatic logic [12:0] rd_next(input logic [12:0] a, input logic [12:0] st);
      return (a == st + 13'h0003) ? st : a + 13'h0001;
   endfunction : rd_next

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      i_sys_rst = 1'b1;
      i_pkt_received = 1'b0;
      repeat (10) @(posedge i_ref_clk);
      #1;
      i_sys_rst = 1'b0;
      rd(`ECB_REG_CTL2, d);
      chk("ctl2 reset", d, `ECB_RST_CTL2);
      rd(5'h1F, d);
      chk("unmapped read", d, 8'h00);
      $display("test reset done");
      // Bits 2:0 are written as ones to see them read as zero; the reserved bit stays clear.
      wr(`ECB_REG_CTL2, 8'hEF);
      rd(`ECB_REG_CTL2, d);
      chk("ctl2 readback", d, 8'hA8);
      chk("sleep on", sleep_lvl, 1'b1);
      chk("low current on", reg_low, 1'b1);
      wr(`ECB_REG_CTL2, 8'h88);
      rd(`ECB_REG_CTL2, d);
      chk("sleep off", sleep_lvl, 1'b0);
      chk("low current awake", reg_low, 1'b0);
      wr(`ECB_REG_CTL2, 8'hA0);
      rd(`ECB_REG_CTL2, d);
      chk("low current clear", reg_low, 1'b0);
      $display("test power done");
      n = 2 + ($unsigned($random(seed)) % 20);
      repeat (n) begin
         @(posedge i_ref_clk);
         #1;
         i_pkt_received = 1'b1;
         @(posedge i_ref_clk);
         #1;
         i_pkt_received = 1'b0;
      end
      wr(`ECB_REG_CTL2, 8'hC0);
      wr(`ECB_REG_CTL2, 8'hC0);
      rd(`ECB_REG_CTL2, d);
      chk("decrement self clear", d, 8'h80);
      wr(`ECB_REG_CTL2, 8'h80);
      rd(`ECB_REG_PKTCNT, d);
      chk("packet count", d, 8'(n - 2));
      $display("test count done");
      s = 13'($unsigned($random(seed)) % 32'h1FF0);
      set_ptr(`ECB_REG_RXST_LO, s);
      set_ptr(`ECB_REG_RXND_LO, s + 13'h0003);
      set_ptr(`ECB_REG_WRPT_LO, s);
      for (int i = 0; i < 4; i++) begin
         bytes[i] = 8'($random(seed));
         i_ecb_host_model.op(4'h2, 5'h00, bytes[i]);
      end
      get_ptr(`ECB_REG_WRPT_LO, q);
      chk("write no wrap", q, s + 13'h0004);
      set_ptr(`ECB_REG_RDPT_LO, s);
      p = s;
      for (int i = 0; i < 6; i++) begin
         i_ecb_host_model.op(4'h1, 5'h00, 8'h00);
         chk("read valid", buf_rvalid, 1'b1);
         chk("read byte", buf_rdata, bytes[i % 4]);
         p = rd_next(p, s);
      end
      get_ptr(`ECB_REG_RDPT_LO, q);
      chk("read wrap", q, p);
      set_ptr(`ECB_REG_WRPT_LO, 13'h1FFF);
      i_ecb_host_model.op(4'h2, 5'h00, 8'h5A);
      get_ptr(`ECB_REG_WRPT_LO, q);
      chk("memory top", q, 13'h0000);
      $display("test buffer done");
      wr(`ECB_REG_CTL2, 8'h00);
      set_ptr(`ECB_REG_RDPT_LO, s);
      i_ecb_host_model.op(4'h3, 5'h00, 8'hA5);
      chk("fixed read byte", buf_rdata, bytes[0]);
      get_ptr(`ECB_REG_RDPT_LO, q);
      chk("read ptr held", q, s);
      get_ptr(`ECB_REG_WRPT_LO, q);
      chk("write ptr held", q, 13'h0000);
      $display("test hold done");
      conclude();
   end
endmodule : ethernet_control_two_and_buffer_tb
